// [rtl/pcps_top.v]
/*
  Phase compensation calibration registers and power sign status register,
  with the mode bits that steer the signs, sticky sign-change events and an
  interrupt. Assumes an APB3 master on pclk and power results from the
  metering core that are synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcps_regs.vh"

module pcps_top #(
  parameter HAS_REACTIVE = 1
) (
  // Clock and reset
  input  wire                     pclk,
  input  wire                     presetn,
  // APB slave
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [17:0]              paddr,
  input  wire [31:0]              pwdata,
  output reg  [31:0]              prdata,
  output reg                      pready,
  output reg                      pslverr,
  // Per-phase power results, phase A in the low slice
  input  wire [3*`PCPS_PWR_W-1:0] total_active,
  input  wire [3*`PCPS_PWR_W-1:0] total_reactive,
  input  wire [3*`PCPS_PWR_W-1:0] apparent,
  input  wire [3*`PCPS_PWR_W-1:0] fund_active,
  input  wire [3*`PCPS_PWR_W-1:0] fund_reactive,
  // Compensation to the phase shifters, phase A in the low slice
  output reg  [29:0]              phase_comp_value,
  output reg  [2:0]               phase_comp_lag,
  // Pulse output path enables
  output reg  [2:0]               pulse_path_enable,
  // Interrupt
  output reg                      irq
);

  // Registers
  reg [9:0]  comp_q [0:2];
  reg [15:0] accumulation_mode_reg_q;
  reg [15:0] computation_mode_reg_q;
  reg [15:0] pulse_output_mode_reg_q;
  reg [8:0]  sign_q;
  reg [8:0]  sign_d;
  reg [8:0]  irq_status_q;
  reg [8:0]  irq_status_d;
  reg [8:0]  irq_mask_q;
  reg [31:0] rdata_d;
  reg        hit_d;

  // Decode
  wire       setup_rd;
  wire       access_wr;
  wire [15:0] idx;
  wire       aligned;

  assign idx       = paddr[17:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  assign setup_rd  = psel & ~penable & ~pready;
  // A write lands only at the edge that completes the access phase
  assign access_wr = psel & penable & pready & pwrite & ~pslverr;

  // Mode fields
  wire       active_sign_source_select;
  wire       reactive_sign_source_select;
  wire [2:0] pulse_path_1_phase_select;
  wire [2:0] pulse_path_2_phase_select;
  wire [2:0] pulse_path_3_phase_select;
  wire [2:0] pulse_path_1_quantity_select;
  wire [2:0] pulse_path_2_quantity_select;
  wire [2:0] pulse_path_3_quantity_select;

  assign active_sign_source_select    = accumulation_mode_reg_q[`PCPS_ACC_ACT_SRC_BIT];
  assign reactive_sign_source_select  = accumulation_mode_reg_q[`PCPS_ACC_REACT_SRC_BIT];
  assign pulse_path_1_phase_select    = computation_mode_reg_q[2:0];
  assign pulse_path_2_phase_select    = computation_mode_reg_q[5:3];
  assign pulse_path_3_phase_select    = computation_mode_reg_q[8:6];
  assign pulse_path_1_quantity_select = pulse_output_mode_reg_q[2:0];
  assign pulse_path_2_quantity_select = pulse_output_mode_reg_q[5:3];
  assign pulse_path_3_quantity_select = pulse_output_mode_reg_q[8:6];

  // Per-phase signs and compensation aliasing
  wire [2:0]  act_neg;
  wire [2:0]  react_neg;
  wire [29:0] comp_eff;
  wire [2:0]  comp_lag;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase
      wire [9:0] v;
      wire [9:0] wide_off;
      assign v = comp_q[g];
      // Offset into the wide alias band; only its low seven bits survive the fold
      assign wide_off = v - `PCPS_COMP_WIDE_BASE;
      assign act_neg[g] = active_sign_source_select ?
                          fund_active[g*`PCPS_PWR_W+`PCPS_PWR_W-1] :
                          total_active[g*`PCPS_PWR_W+`PCPS_PWR_W-1];
      assign react_neg[g] = (HAS_REACTIVE != 0) &
                            (reactive_sign_source_select ?
                             fund_reactive[g*`PCPS_PWR_W+`PCPS_PWR_W-1] :
                             total_reactive[g*`PCPS_PWR_W+`PCPS_PWR_W-1]);
      // Codes outside the two legal bands fold onto the lead band so the
      // shifter never sees a value it cannot realise
      assign comp_eff[g*10 +: 10] =
        (v >= `PCPS_COMP_WIDE_BASE) ?
          (`PCPS_COMP_WIDE_TARGET + {3'h0, wide_off[6:0]}) :
        (v > `PCPS_COMP_LAG_MAX - `PCPS_COMP_LAG_MAX + `PCPS_COMP_ALIAS_HI &&
         v < `PCPS_COMP_LAG_MIN) ? v :
        (v >= `PCPS_COMP_ALIAS_LO && v <= `PCPS_COMP_ALIAS_HI) ?
          (v - `PCPS_COMP_ALIAS_SHIFT) :
        v;
      assign comp_lag[g] = (v >= `PCPS_COMP_LAG_MIN) && (v <= `PCPS_COMP_LAG_MAX);
    end
  endgenerate

  // Pulse path sums
  wire [2:0] sum_neg;
  wire [2:0] path_en;
  wire [8:0] psel_all;
  wire [8:0] qsel_all;

  assign psel_all = {pulse_path_3_phase_select, pulse_path_2_phase_select, pulse_path_1_phase_select};
  assign qsel_all = {pulse_path_3_quantity_select, pulse_path_2_quantity_select,
                     pulse_path_1_quantity_select};

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_path
      pcps_sum_sign u_sum (
        .total_active    (total_active),
        .total_reactive  (total_reactive),
        .apparent        (apparent),
        .fund_active     (fund_active),
        .fund_reactive   (fund_reactive),
        .phase_select    (psel_all[g*3 +: 3]),
        .quantity_select (qsel_all[g*3 +: 3]),
        .sum_neg         (sum_neg[g]),
        .pulse_enable    (path_en[g])
      );
    end
  endgenerate

  // Sign status assembly, refreshed every cycle from the power results
  always @* begin
    sign_d = `PCPS_SIGN_RESET;
    sign_d[`PCPS_SIGN_ACT_A +: 3]   = act_neg;
    sign_d[`PCPS_SIGN_REACT_A +: 3] = react_neg;
    sign_d[`PCPS_SIGN_SUM1]         = sum_neg[0];
    sign_d[`PCPS_SIGN_SUM2]         = sum_neg[1];
    sign_d[`PCPS_SIGN_SUM3]         = sum_neg[2];
  end

  // Sticky sign-change events; a new change beats a same-cycle clear
  always @* begin
    irq_status_d = irq_status_q;
    if (access_wr && idx == `PCPS_IDX_IRQ_STATUS) begin
      irq_status_d = irq_status_d & ~pwdata[8:0];
    end
    irq_status_d = irq_status_d | (sign_d ^ sign_q);
  end

  // Read mux and address decode
  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d   = aligned;
    case (idx)
      `PCPS_IDX_PHASE_A_COMP: rdata_d = {22'h000000, comp_q[0]};
      `PCPS_IDX_PHASE_B_COMP: rdata_d = {22'h000000, comp_q[1]};
      `PCPS_IDX_PHASE_C_COMP: rdata_d = {22'h000000, comp_q[2]};
      `PCPS_IDX_SIGN_STATUS:  rdata_d = {23'h000000, sign_q};
      `PCPS_IDX_ACCUM_MODE:   rdata_d = {16'h0000, accumulation_mode_reg_q};
      `PCPS_IDX_COMPUTE_MODE: rdata_d = {16'h0000, computation_mode_reg_q};
      `PCPS_IDX_PULSE_MODE:   rdata_d = {16'h0000, pulse_output_mode_reg_q};
      `PCPS_IDX_IRQ_STATUS:   rdata_d = {23'h000000, irq_status_q};
      `PCPS_IDX_IRQ_MASK:     rdata_d = {23'h000000, irq_mask_q};
      default:                hit_d   = 1'b0;
    endcase
    if (!hit_d) begin
      rdata_d = 32'h0000_0000;
    end
  end

  // APB handshake: the answer is prepared in the setup cycle, so every
  // access completes in its first access cycle with no wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_rd;
      pslverr <= setup_rd & ~hit_d;
      if (setup_rd && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // Writable registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_q[0]               <= `PCPS_COMP_RESET;
      comp_q[1]               <= `PCPS_COMP_RESET;
      comp_q[2]               <= `PCPS_COMP_RESET;
      accumulation_mode_reg_q <= `PCPS_ACC_RESET;
      computation_mode_reg_q  <= `PCPS_COMPUTE_RESET;
      pulse_output_mode_reg_q <= `PCPS_PULSE_RESET;
      irq_mask_q              <= 9'h000;
    end else if (access_wr) begin
      case (idx)
        // Upper 22 bits are dropped; they steer nothing
        `PCPS_IDX_PHASE_A_COMP: comp_q[0] <= pwdata[`PCPS_COMP_MSB:0];
        `PCPS_IDX_PHASE_B_COMP: comp_q[1] <= pwdata[`PCPS_COMP_MSB:0];
        `PCPS_IDX_PHASE_C_COMP: comp_q[2] <= pwdata[`PCPS_COMP_MSB:0];
        `PCPS_IDX_ACCUM_MODE:   accumulation_mode_reg_q <= pwdata[15:0];
        `PCPS_IDX_COMPUTE_MODE: computation_mode_reg_q  <= pwdata[15:0];
        `PCPS_IDX_PULSE_MODE:   pulse_output_mode_reg_q <= pwdata[15:0];
        `PCPS_IDX_IRQ_MASK:     irq_mask_q              <= pwdata[8:0];
        default: begin
        end
      endcase
    end
  end

  // Status, interrupt and datapath outputs; sign status takes no bus write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sign_q            <= `PCPS_SIGN_RESET;
      irq_status_q      <= 9'h000;
      irq               <= 1'b0;
      phase_comp_value  <= 30'h00000000;
      phase_comp_lag    <= 3'h0;
      pulse_path_enable <= 3'h0;
    end else begin
      sign_q            <= sign_d;
      irq_status_q      <= irq_status_d;
      irq               <= |(irq_status_d & irq_mask_q);
      phase_comp_value  <= comp_eff;
      phase_comp_lag    <= comp_lag;
      pulse_path_enable <= path_en;
    end
  end

endmodule
`default_nettype wire

// [rtl/pcps_regs.vh]
/*
  Register map, field positions and reset values of the phase compensation
  and power sign register bank. Assumes an APB slave with 32-bit data where
  each register index sits at byte address four times the index.
*/
`ifndef PCPS_REGS_VH
`define PCPS_REGS_VH

// Register indices (byte address = index * 4)
`define PCPS_IDX_PHASE_A_COMP    16'he614
`define PCPS_IDX_PHASE_B_COMP    16'he615
`define PCPS_IDX_PHASE_C_COMP    16'he616
`define PCPS_IDX_SIGN_STATUS     16'he617
`define PCPS_IDX_ACCUM_MODE      16'he620
`define PCPS_IDX_COMPUTE_MODE    16'he621
`define PCPS_IDX_PULSE_MODE      16'he622
`define PCPS_IDX_IRQ_STATUS      16'he623
`define PCPS_IDX_IRQ_MASK        16'he624

// Phase compensation field
`define PCPS_COMP_MSB            9
`define PCPS_COMP_RESET          10'h000
`define PCPS_COMP_LEAD_MAX       10'h17f
`define PCPS_COMP_ALIAS_LO       10'h180
`define PCPS_COMP_ALIAS_HI       10'h1ff
`define PCPS_COMP_LAG_MIN        10'h200
`define PCPS_COMP_LAG_MAX        10'h23f
`define PCPS_COMP_ALIAS_SHIFT    10'h080
`define PCPS_COMP_WIDE_BASE      10'h240
`define PCPS_COMP_WIDE_TARGET    10'h100

// Sign status bit positions
`define PCPS_SIGN_ACT_A          0
`define PCPS_SIGN_SUM1           3
`define PCPS_SIGN_REACT_A        4
`define PCPS_SIGN_SUM2           7
`define PCPS_SIGN_SUM3           8
`define PCPS_SIGN_MSB            8
`define PCPS_SIGN_RESET          9'h000

// Mode register fields
`define PCPS_ACC_ACT_SRC_BIT     6
`define PCPS_ACC_REACT_SRC_BIT   7
`define PCPS_ACC_RESET           16'h0000
`define PCPS_COMPUTE_RESET       16'h01ff
`define PCPS_PULSE_RESET         16'h0088

// Pulse path quantity codes
`define PCPS_Q_TOTAL_ACT         3'h0
`define PCPS_Q_TOTAL_REACT       3'h1
`define PCPS_Q_APPARENT          3'h2
`define PCPS_Q_FUND_ACT          3'h3
`define PCPS_Q_FUND_REACT        3'h4

`define PCPS_PWR_W               24

`endif

// [rtl/pcps_sum_sign.v]
/*
  Summed power sign for one pulse output path: picks the quantity chosen by
  the quantity select, adds the phases chosen by the phase select and reports
  the sign. Purely combinational; the caller registers the results.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcps_regs.vh"

module pcps_sum_sign (
  // Per-phase powers, phase A in the low slice
  input  wire [3*`PCPS_PWR_W-1:0] total_active,
  input  wire [3*`PCPS_PWR_W-1:0] total_reactive,
  input  wire [3*`PCPS_PWR_W-1:0] apparent,
  input  wire [3*`PCPS_PWR_W-1:0] fund_active,
  input  wire [3*`PCPS_PWR_W-1:0] fund_reactive,
  // Path selection
  input  wire [2:0]               phase_select,
  input  wire [2:0]               quantity_select,
  // Results
  output reg                      sum_neg,
  output reg                      pulse_enable
);

  reg [3*`PCPS_PWR_W-1:0] chosen;
  reg [`PCPS_PWR_W+1:0]   sum;
  integer                 i;

  always @* begin
    chosen       = {3*`PCPS_PWR_W{1'b0}};
    pulse_enable = 1'b1;
    case (quantity_select)
      `PCPS_Q_TOTAL_ACT:   chosen = total_active;
      `PCPS_Q_TOTAL_REACT: chosen = total_reactive;
      `PCPS_Q_APPARENT:    chosen = apparent;
      `PCPS_Q_FUND_ACT:    chosen = fund_active;
      `PCPS_Q_FUND_REACT:  chosen = fund_reactive;
      default:             pulse_enable = 1'b0;
    endcase
    sum = {(`PCPS_PWR_W+2){1'b0}};
    for (i = 0; i < 3; i = i + 1) begin
      if (phase_select[i]) begin
        sum = sum + {{2{chosen[i*`PCPS_PWR_W+`PCPS_PWR_W-1]}}, chosen[i*`PCPS_PWR_W +: `PCPS_PWR_W]};
      end
    end
    // A reserved code makes no pulse and reports a positive sum
    sum_neg = pulse_enable & sum[`PCPS_PWR_W+1];
  end

endmodule
`default_nettype wire

// [tb/pcps_top_asserts.sv]
/*
  Port checker for the phase compensation and power sign bank.
  Assumes zero-wait APB and registered compensation outputs.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcps_regs.vh"

module pcps_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Outputs
  input wire logic [29:0] phase_comp_value,
  input wire logic [2:0]  phase_comp_lag,
  input wire logic        irq
);
  function automatic logic lag(input logic [9:0] v);
    lag = v >= 10'h200 && v <= 10'h23f;
  endfunction
  function automatic logic ok(input logic [9:0] v);
    ok = v < 10'h180 || lag(v);
  endfunction
  wire acc_rd = psel && penable && pready && !pwrite;
  wire rd_sign = acc_rd && paddr[17:2] == `PCPS_IDX_SIGN_STATUS;
  wire rd_comp = acc_rd && paddr[17:2] >= `PCPS_IDX_PHASE_A_COMP && paddr[17:2] <= `PCPS_IDX_PHASE_C_COMP;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  setup_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  error_ready_a: assert property (pslverr |-> pready && psel && penable) else $error("stray error");
  reset_quiet_a: assert property (disable iff (1'b0) !presetn [*2] |-> !irq && phase_comp_value == 30'h0)
    else $error("outputs active in reset");
  comp_fold_a: assert property (ok(phase_comp_value[9:0]) && ok(phase_comp_value[19:10]) && ok(phase_comp_value[29:20]))
    else $error("compensation code not folded");
  lag_flag_a: assert property (phase_comp_lag == {lag(phase_comp_value[29:20]), lag(phase_comp_value[19:10]),
    lag(phase_comp_value[9:0])}) else $error("lag flag wrong");
  sign_upper_a: assert property (rd_sign |-> prdata[31:9] == 23'h0) else $error("sign upper bits set");
  comp_upper_a: assert property (rd_comp |-> prdata[31:10] == 22'h0) else $error("comp upper bits set");

  cover property (rd_sign && prdata[8:0] != 9'h0);
  cover property (pslverr);
  cover property ($rose(irq));
  cover property (|phase_comp_lag);
endmodule

bind pcps_top pcps_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_comp_value(phase_comp_value),
  .phase_comp_lag(phase_comp_lag), .irq(irq));
`default_nettype wire

// [tb/test_phase_cal_power_sign_regs.sv]
/*
  Self-checking bench for the phase compensation and power sign bank.
  Drives APB and the power results directly; expects zero-wait APB.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pcps_regs.vh"

module test_phase_cal_power_sign_regs;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata, r;
  logic        e;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq;
  logic [71:0] total_active, total_reactive, apparent, fund_active, fund_reactive;
  wire  [29:0] phase_comp_value;
  wire  [2:0]  phase_comp_lag, pulse_path_enable;
  wire  [31:0] prdata_nr;
  int          error_cnt, checked;
  // Compensation codes at every range edge and the folded codes they must yield
  logic [9:0]  code [8] = '{10'h000, 10'h17f, 10'h180, 10'h1ff, 10'h200, 10'h23f, 10'h240, 10'h3ff};
  logic [9:0]  eff [8] = '{10'h000, 10'h17f, 10'h100, 10'h17f, 10'h200, 10'h23f, 10'h100, 10'h13f};
  logic [7:0]  lagv = 8'h30;

  pcps_top #(.HAS_REACTIVE(1)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .total_active(total_active), .total_reactive(total_reactive), .apparent(apparent),
    .fund_active(fund_active), .fund_reactive(fund_reactive), .phase_comp_value(phase_comp_value),
    .phase_comp_lag(phase_comp_lag), .pulse_path_enable(pulse_path_enable), .irq(irq));

  // Variant without reactive measurement shares the bus; only its read data is watched
  pcps_top #(.HAS_REACTIVE(0)) DUT_NR (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_nr), .pready(), .pslverr(),
    .total_active(total_active), .total_reactive(total_reactive), .apparent(apparent),
    .fund_active(fund_active), .fund_reactive(fund_reactive), .phase_comp_value(),
    .phase_comp_lag(), .pulse_path_enable(), .irq());

  function automatic logic [71:0] p3(input int a, input int b, input int c);
    p3 = {c[23:0], b[23:0], a[23:0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Holds the request until pready is sampled high; only the watchdog ends a hang
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    xfer(1'b1, idx, d, x, y);
  endtask

  task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    logic        y;
    xfer(1'b0, idx, 32'h0, x, y);
    chk(nm, exp, x);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    repeat (4000) @(posedge pclk);
    error_cnt++;
    $display("[ERR] run expected done seen running");
    give_verdict();
  end

  initial begin
    logic [15:0] idx;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {total_active, total_reactive, apparent, fund_active, fund_reactive} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 3; k++) rdc("comp_reset", `PCPS_IDX_PHASE_A_COMP + 16'(k), 32'h0);
    rdc("sign_reset", `PCPS_IDX_SIGN_STATUS, 32'h0);
    rdc("compute_reset", `PCPS_IDX_COMPUTE_MODE, 32'h1ff);
    rdc("pulse_reset", `PCPS_IDX_PULSE_MODE, 32'h88);
    chk("pulse_en", 32'h7, {29'h0, pulse_path_enable});
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      idx = `PCPS_IDX_PHASE_A_COMP + 16'(i % 3);
      wr(idx, {22'h3f, code[i]});
      repeat (2) @(posedge pclk);
      chk("comp_eff", {22'h0, eff[i]}, {22'h0, phase_comp_value[10*(i%3) +: 10]});
      chk("comp_lag", {31'h0, lagv[i]}, {31'h0, phase_comp_lag[i%3]});
      rdc("comp_rd", idx, {22'h0, code[i]});
    end
    $display("test compensation done");
    total_active <= p3(-100, 10, -5);
    total_reactive <= p3(20, -50, 10);
    apparent <= p3(1, 1, 1);
    fund_active <= p3(5, -5, 5);
    fund_reactive <= p3(-1, 2, -3);
    repeat (2) @(posedge pclk);
    rdc("sign_total", `PCPS_IDX_SIGN_STATUS, 32'had);
    chk("sign_noreact", 32'h8d, prdata_nr);
    wr(`PCPS_IDX_ACCUM_MODE, 32'hc0);
    rdc("sign_fund", `PCPS_IDX_SIGN_STATUS, 32'hda);
    wr(`PCPS_IDX_PULSE_MODE, 32'h163);
    rdc("sign_codes", `PCPS_IDX_SIGN_STATUS, 32'hd2);
    chk("pulse_en", 32'h3, {29'h0, pulse_path_enable});
    wr(`PCPS_IDX_COMPUTE_MODE, 32'h1d7);
    rdc("sign_terms", `PCPS_IDX_SIGN_STATUS, 32'h52);
    wr(`PCPS_IDX_PULSE_MODE, 32'h17e);
    rdc("sign_resv", `PCPS_IDX_SIGN_STATUS, 32'h52);
    chk("pulse_en", 32'h0, {29'h0, pulse_path_enable});
    wr(`PCPS_IDX_SIGN_STATUS, 32'hffff);
    rdc("sign_ro", `PCPS_IDX_SIGN_STATUS, 32'h52);
    xfer(1'b0, 16'he630, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    $display("test sign status done");
    wr(`PCPS_IDX_IRQ_STATUS, 32'h1ff);
    rdc("irq_clear", `PCPS_IDX_IRQ_STATUS, 32'h0);
    wr(`PCPS_IDX_IRQ_MASK, 32'h1);
    fund_active <= p3(-5, -5, 5);
    repeat (4) @(posedge pclk);
    chk("irq_set", 32'h1, {31'h0, irq});
    rdc("irq_stat", `PCPS_IDX_IRQ_STATUS, 32'h1);
    wr(`PCPS_IDX_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`PCPS_IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_unmask", 32'h1, {31'h0, irq});
    wr(`PCPS_IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_w1c", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    give_verdict();
  end
endmodule
`default_nettype wire
